// ==== serial_unit_defines.svh ====
// Offsets, field positions, reset values and timing counts of the serial unit.
`ifndef SERIAL_UNIT_DEFINES_SVH
`define SERIAL_UNIT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL_ONE   8'h72
`define OFS_CONTROL_TWO   8'h73
`define OFS_STATUS_ONE    8'h74
`define OFS_STATUS_TWO    8'h75
`define OFS_DATA_HIGH     8'h76
`define OFS_DATA_LOW      8'h77

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define C1_CHAR_LEN       4
`define C1_PARITY_ON      1
`define C1_PARITY_ODD     0
`define C2_TX_EMPTY_IE    7
`define C2_TX_DONE_IE     6
`define C2_RX_FULL_IE     5
`define C2_LINE_QUIET_IE  4
`define C2_TX_ON          3
`define C2_RX_ON          2
`define C2_RX_SLEEP       1
`define C2_BREAK_SEND     0
`define S1_TX_EMPTY       7
`define S1_TX_DONE        6
`define S1_RX_FULL        5
`define S1_IDLE           4
`define S1_OVERRUN        3
`define S1_NOISE          2
`define S1_STOP_FAULT     1
`define S1_PARITY         0
`define DH_RX_NINTH       7
`define DH_TX_NINTH       6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_CONTROL       8'h00
`define RST_STATUS_ONE    8'hc0

// ----------------------------------------------------------------------------
// Timing counts in ticks of the bit-rate clock
// ----------------------------------------------------------------------------
`define TICKS_PER_BIT     5'd16
`define SAMPLE_A          4'h7
`define SAMPLE_B          4'h8
`define SAMPLE_C          4'h9
`define LAST_TICK         4'hf

`endif

// ==== serial_unit_pkg.sv ====
// Types shared by the serial unit.
package serial_unit_pkg;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SEND  = 2'b01,
    TX_BREAK = 2'b10
  } tx_state_t;

  typedef logic [7:0] byte_t;

endpackage

// ==== async_serial_unit.sv ====
// Control, status, data buffers and interrupt request of the serial unit.
// What this block does
// - Transmit-empty flag interrupts while its enable set.
// - Transmit-done flag interrupts while its enable set.
// - Receive-full or overrun interrupts while enabled.
// - Idle-line flag interrupts while its enable set.
// - Sleep puts receiver in wait, inhibits receiver interrupts.
// - Break characters repeat while break_send stays set.
// - Enabling transmitter sets empty and done flags.
// - Empty flag cleared by status read, data write.
// - Done flag set idle, cleared read-then-write.
// - Full flag set on load, cleared read-then-read.
// - Idle flag suppressed asleep, rearms after activity.
// - Idle needs one character time of ones.
// - Overrun keeps old character, sets overrun flag.
// - Noise flag on non-unanimous bit samples.
// - Stop-bit fault when stop samples zero.
// - Parity fault on wrong received parity.
// - Noise, stop and parity flags describe buffer, never interrupt.
// - Status two shows only busy in bit zero.
// - Data reads receive buffer, writes transmit buffer.
// - Data high holds ninth bits, rest zero.
// - Disabling transmitter finishes character, drops queue.
// - Eight or nine data bits by length select.
`timescale 1ns/10ps
`default_nettype none
`include "serial_unit_defines.svh"

module async_serial_unit #(
  parameter int TICK_DIV = 8
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_nrst,
  input  wire logic [7:0]            i_addr,
  input  wire serial_unit_pkg::byte_t i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [7:0]            o_rdata,
  input  wire logic                  i_rx_pin,
  output logic                       o_tx_pin,
  output logic                       o_tx_oe,
  output logic                       o_irq
);
  import serial_unit_pkg::*;

  localparam byte_t ST1_RST = `RST_STATUS_ONE;

  // A divider outside this range cannot be held by the tick counter.
  if (TICK_DIV < 1 || TICK_DIV > 65535)
  begin : g_bad_div
    $error("TICK_DIV must lie in 1 to 65535");
  end

  // Parity bit over the data bits below the parity position.
  function automatic logic par_of(input logic [8:0] d, input logic nine, input logic odd);
    par_of = (nine ? (^d[7:0]) : (^d[6:0])) ^ odd;
  endfunction

  // Majority of three samples.
  function automatic logic vote(input logic [2:0] s);
    vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // --------------------------------------------------------------------------
  // Registers and shared state
  // --------------------------------------------------------------------------
  byte_t       ctl1_ff;
  byte_t       ctl2_ff;
  logic        tx_buffer_empty_ff, tc_ff, rx_buffer_full_ff, idle_ff, or_ff, nf_ff, fe_ff, pf_ff;
  byte_t       arm_ff;
  logic [8:0]  rx_buf_ff;
  logic [8:0]  tx_buf_ff;
  logic        tx_ninth_ff;
  logic        tx_buf_valid_ff;
  logic        tx_on_d_ff;
  logic [15:0] div_ff;
  logic        tick_ff;
  logic [2:0]  rx_sync_ff;
  logic        rx_line_ff;
  rx_state_t   rx_state_ff;
  logic [3:0]  rx_cnt_ff;
  logic [3:0]  rx_bit_ff;
  logic [2:0]  rx_smp_ff;
  logic        rx_noise_ff;
  logic [8:0]  rx_shift_ff;
  logic [7:0]  ones_ff;
  logic        line_armed_ff;
  tx_state_t   tx_state_ff;
  logic [10:0] tx_shift_ff;
  logic [3:0]  tx_left_ff;
  logic [3:0]  tx_cnt_ff;
  byte_t       rdata_ff;
  logic        tx_pin_ff, tx_oe_ff, irq_ff;

  logic        nine, par_on, par_odd, tx_on, rx_on, rx_sleep, brk;
  logic        st1_rd, dl_rd, dl_wr, dh_wr;
  logic [3:0]  frame_bits;
  logic [7:0]  char_ticks;
  byte_t       status_one;

  assign nine       = ctl1_ff[`C1_CHAR_LEN];
  assign par_on     = ctl1_ff[`C1_PARITY_ON];
  assign par_odd    = ctl1_ff[`C1_PARITY_ODD];
  assign tx_on      = ctl2_ff[`C2_TX_ON];
  assign rx_on      = ctl2_ff[`C2_RX_ON];
  assign rx_sleep   = ctl2_ff[`C2_RX_SLEEP];
  assign brk        = ctl2_ff[`C2_BREAK_SEND];
  assign st1_rd     = i_rd && (i_addr == `OFS_STATUS_ONE);
  assign dl_rd      = i_rd && (i_addr == `OFS_DATA_LOW);
  assign dl_wr      = i_wr && (i_addr == `OFS_DATA_LOW);
  assign dh_wr      = i_wr && (i_addr == `OFS_DATA_HIGH);
  assign frame_bits = nine ? 4'd11 : 4'd10;
  assign char_ticks = {frame_bits, 4'h0};
  assign status_one = {tx_buffer_empty_ff, tc_ff, rx_buffer_full_ff, idle_ff, or_ff, nf_ff, fe_ff, pf_ff};

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      ctl1_ff <= `RST_CONTROL;
      ctl2_ff <= `RST_CONTROL;
    end
    else if (i_wr && (i_addr == `OFS_CONTROL_ONE))
    begin
      ctl1_ff <= i_wdata & 8'h13;
    end
    else if (i_wr && (i_addr == `OFS_CONTROL_TWO))
    begin
      ctl2_ff <= i_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Acknowledge sequence: a status read arms the bits that were set.
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      arm_ff <= 8'h00;
    end
    else if (st1_rd)
    begin
      arm_ff <= status_one;
    end
    else
    begin
      if (dl_wr)
      begin
        arm_ff[7:6] <= 2'b00;
      end
      if (dl_rd)
      begin
        arm_ff[5:0] <= 6'h00;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bit-rate tick and receive pin synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    // Ticks go on while the pin is still owned, so that it is released on a tick.
    if (!i_nrst || !(tx_on || rx_on || tx_state_ff != TX_IDLE || tx_oe_ff))
    begin
      div_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end
    else if (div_ff == 16'(TICK_DIV - 1))
    begin
      div_ff  <= 16'h0000;
      tick_ff <= 1'b1;
    end
    else
    begin
      div_ff  <= div_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      rx_sync_ff <= 3'b111;
      rx_line_ff <= 1'b1;
    end
    else
    begin
      rx_sync_ff <= {rx_sync_ff[1:0], i_rx_pin};
      if (rx_sync_ff[1] == rx_sync_ff[2])
      begin
        rx_line_ff <= rx_sync_ff[2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  logic       rx_bit_end, rx_bit_val, rx_done, rx_load, rx_over;
  logic [8:0] rx_word;
  assign rx_bit_end = tick_ff && (rx_cnt_ff == `LAST_TICK);
  assign rx_bit_val = vote(rx_smp_ff);
  assign rx_done    = rx_bit_end && (rx_state_ff == RX_STOP);
  assign rx_word    = nine ? rx_shift_ff : {1'b0, rx_shift_ff[7:0]};
  assign rx_load    = rx_done && !rx_sleep && !rx_buffer_full_ff;
  assign rx_over    = rx_done && !rx_sleep && rx_buffer_full_ff;

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      rx_state_ff <= RX_IDLE;
      rx_cnt_ff   <= 4'h0;
      rx_bit_ff   <= 4'h0;
      rx_smp_ff   <= 3'b111;
      rx_noise_ff <= 1'b0;
      rx_shift_ff <= 9'h000;
    end
    else if (!rx_on)
    begin
      rx_state_ff <= RX_IDLE;
    end
    else if (tick_ff)
    begin
      rx_cnt_ff <= (rx_state_ff == RX_IDLE) ? 4'h0 : rx_cnt_ff + 4'h1;
      if (rx_cnt_ff == `SAMPLE_A || rx_cnt_ff == `SAMPLE_B || rx_cnt_ff == `SAMPLE_C)
      begin
        rx_smp_ff <= {rx_smp_ff[1:0], rx_line_ff};
      end
      if (rx_bit_end && !(&rx_smp_ff) && (|rx_smp_ff))
      begin
        rx_noise_ff <= 1'b1;
      end
      case (rx_state_ff)
        RX_IDLE:
        begin
          if (!rx_line_ff)
          begin
            rx_state_ff <= RX_START;
            rx_noise_ff <= 1'b0;
            rx_bit_ff   <= 4'h0;
          end
        end
        RX_START:
        begin
          if (rx_bit_end)
          begin
            rx_state_ff <= rx_bit_val ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_bit_end)
          begin
            rx_shift_ff[rx_bit_ff] <= rx_bit_val;
            rx_bit_ff              <= rx_bit_ff + 4'h1;
            if (rx_bit_ff == frame_bits - 4'd3)
            begin
              rx_state_ff <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (rx_bit_end)
          begin
            rx_state_ff <= RX_IDLE;
          end
        end
        default:
        begin
          rx_state_ff <= RX_IDLE;
        end
      endcase
    end
  end

  // Receive buffer and its flags; a set in the clearing cycle wins.
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      rx_buf_ff <= 9'h000;
      rx_buffer_full_ff   <= 1'b0;
      or_ff     <= 1'b0;
      nf_ff     <= 1'b0;
      fe_ff     <= 1'b0;
      pf_ff     <= 1'b0;
    end
    else
    begin
      if (dl_rd && !st1_rd)
      begin
        rx_buffer_full_ff <= rx_buffer_full_ff & ~arm_ff[`S1_RX_FULL];
        or_ff   <= or_ff & ~arm_ff[`S1_OVERRUN];
        nf_ff   <= nf_ff & ~arm_ff[`S1_NOISE];
        fe_ff   <= fe_ff & ~arm_ff[`S1_STOP_FAULT];
        pf_ff   <= pf_ff & ~arm_ff[`S1_PARITY];
      end
      if (rx_load)
      begin
        rx_buf_ff <= rx_word;
        rx_buffer_full_ff   <= 1'b1;
        nf_ff     <= rx_noise_ff || (!(&rx_smp_ff) && (|rx_smp_ff));
        fe_ff     <= !rx_bit_val;
        pf_ff     <= par_on && (par_of(rx_word, nine, par_odd) !=
                     (nine ? rx_word[8] : rx_word[7]));
      end
      if (rx_over)
      begin
        or_ff <= 1'b1;
      end
    end
  end

  // Idle line: a full character of ones after activity.
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      ones_ff       <= 8'h00;
      line_armed_ff <= 1'b0;
      idle_ff       <= 1'b0;
    end
    else
    begin
      if (dl_rd && !st1_rd && arm_ff[`S1_IDLE])
      begin
        idle_ff <= 1'b0;
      end
      if (!rx_on || !rx_line_ff)
      begin
        ones_ff       <= 8'h00;
        line_armed_ff <= rx_on;
      end
      else if (tick_ff && line_armed_ff)
      begin
        ones_ff <= ones_ff + 8'h01;
        if (ones_ff == char_ticks - 8'h01)
        begin
          line_armed_ff <= 1'b0;
          idle_ff       <= !rx_sleep;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  logic        tx_bit_end, tx_finish;
  logic [8:0]  tx_data;
  logic [10:0] tx_frame;
  assign tx_bit_end = tick_ff && (tx_cnt_ff == `LAST_TICK);
  assign tx_finish  = tx_bit_end && (tx_left_ff == 4'h1) && (tx_state_ff != TX_IDLE);
  assign tx_data    = nine ? tx_buf_ff : {1'b1, tx_buf_ff[7:0]};
  assign tx_frame   = par_on
                    ? (nine ? {1'b1, par_of(tx_data, 1'b1, par_odd), tx_data[7:0], 1'b0}
                            : {2'b11, par_of(tx_data, 1'b0, par_odd), tx_data[6:0], 1'b0})
                    : {1'b1, tx_data, 1'b0};

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      tx_state_ff <= TX_IDLE;
      tx_shift_ff <= 11'h7ff;
      tx_left_ff  <= 4'h0;
      tx_cnt_ff   <= 4'h0;
    end
    else if (tick_ff)
    begin
      tx_cnt_ff <= (tx_state_ff == TX_IDLE) ? 4'h0 : tx_cnt_ff + 4'h1;
      if (tx_state_ff == TX_IDLE || tx_finish)
      begin
        if (tx_on && brk)
        begin
          tx_state_ff <= TX_BREAK;
          tx_shift_ff <= 11'h000;
          tx_left_ff  <= frame_bits;
        end
        else if (tx_on && tx_buf_valid_ff)
        begin
          tx_state_ff <= TX_SEND;
          tx_shift_ff <= tx_frame;
          tx_left_ff  <= frame_bits;
        end
        else
        begin
          tx_state_ff <= TX_IDLE;
          tx_shift_ff <= 11'h7ff;
        end
      end
      else if (tx_bit_end)
      begin
        tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
        tx_left_ff  <= tx_left_ff - 4'h1;
      end
    end
  end

  // Transmit buffer and flags; a set in the clearing cycle wins.
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      tx_buf_ff       <= 9'h000;
      tx_ninth_ff     <= 1'b0;
      tx_buf_valid_ff <= 1'b0;
      tx_on_d_ff      <= 1'b0;
      tx_buffer_empty_ff         <= ST1_RST[`S1_TX_EMPTY];
      tc_ff           <= ST1_RST[`S1_TX_DONE];
    end
    else
    begin
      tx_on_d_ff <= tx_on;
      if (dh_wr)
      begin
        tx_ninth_ff <= i_wdata[`DH_TX_NINTH];
      end
      if (dl_wr && !st1_rd)
      begin
        tx_buffer_empty_ff <= tx_buffer_empty_ff & ~arm_ff[`S1_TX_EMPTY];
        tc_ff   <= tc_ff & ~arm_ff[`S1_TX_DONE];
      end
      if (dl_wr && tx_on)
      begin
        tx_buf_ff       <= {tx_ninth_ff, i_wdata};
        tx_buf_valid_ff <= 1'b1;
      end
      else if (!tx_on)
      begin
        tx_buf_valid_ff <= 1'b0;
      end
      else if (tick_ff && (tx_state_ff == TX_IDLE || tx_finish) && !brk && tx_buf_valid_ff)
      begin
        tx_buf_valid_ff <= 1'b0;
        tx_buffer_empty_ff         <= 1'b1;
      end
      if (tx_on && !tx_on_d_ff)
      begin
        tx_buffer_empty_ff <= 1'b1;
        tc_ff   <= 1'b1;
      end
      if (tick_ff && (tx_state_ff == TX_IDLE || tx_finish) &&
          !(tx_on && (brk || tx_buf_valid_ff)) && (tx_finish || !tx_on))
      begin
        tc_ff   <= 1'b1;
        tx_buffer_empty_ff <= tx_buffer_empty_ff | !tx_on;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin, interrupt and read data outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      tx_pin_ff <= 1'b1;
      tx_oe_ff  <= 1'b0;
    end
    else
    begin
      tx_pin_ff <= tx_shift_ff[0];
      if (tx_on)
      begin
        tx_oe_ff <= 1'b1;
      end
      else if (tick_ff && tx_state_ff == TX_IDLE)
      begin
        tx_oe_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= (ctl2_ff[`C2_TX_EMPTY_IE] && tx_buffer_empty_ff)
             || (ctl2_ff[`C2_TX_DONE_IE] && tc_ff)
             || (ctl2_ff[`C2_RX_FULL_IE] && !rx_sleep && (rx_buffer_full_ff || or_ff))
             || (ctl2_ff[`C2_LINE_QUIET_IE] && !rx_sleep && idle_ff);
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      rdata_ff <= 8'h00;
    end
    else if (i_rd)
    begin
      if (i_addr == `OFS_CONTROL_ONE)
      begin
        rdata_ff <= ctl1_ff;
      end
      else if (i_addr == `OFS_CONTROL_TWO)
      begin
        rdata_ff <= ctl2_ff;
      end
      else if (i_addr == `OFS_STATUS_ONE)
      begin
        rdata_ff <= status_one;
      end
      else if (i_addr == `OFS_STATUS_TWO)
      begin
        rdata_ff <= {7'h00, rx_state_ff != RX_IDLE};
      end
      else if (i_addr == `OFS_DATA_HIGH)
      begin
        rdata_ff <= {rx_buf_ff[8], tx_ninth_ff, 6'h00};
      end
      else if (i_addr == `OFS_DATA_LOW)
      begin
        rdata_ff <= rx_buf_ff[7:0];
      end
      else
      begin
        rdata_ff <= 8'h00;
      end
    end
  end

  assign o_rdata  = rdata_ff;
  assign o_tx_pin = tx_pin_ff;
  assign o_tx_oe  = tx_oe_ff;
  assign o_irq    = irq_ff;

endmodule // async_serial_unit
`default_nettype wire

// ==== serial_unit_checker.sv ====
// Checker of bus, interrupt and pin relations of the serial unit.
`timescale 1ns/10ps
`default_nettype none
module serial_unit_checker (
  input wire logic                   i_mclk,
  input wire logic                   i_nrst,
  input wire logic [7:0]             i_addr,
  input wire serial_unit_pkg::byte_t i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [7:0]             o_rdata,
  input wire logic                   i_rx_pin,
  input wire logic                   o_tx_pin,
  input wire logic                   o_tx_oe,
  input wire logic                   o_irq
);
  import serial_unit_pkg::*;
  logic [7:0] ctl_ff;
  // Shadow of control_two as software last wrote it.
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      ctl_ff <= 8'h00;
    else if (i_wr && i_addr == 8'h73)
      ctl_ff <= i_wdata;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  property p_rst_quiet;
    disable iff (1'b0) $rose(i_nrst) |-> !o_irq && !o_tx_oe && o_tx_pin;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  property p_s2_zero;
    i_rd && i_addr == 8'h75 |=> o_rdata[7:1] == 7'h00;
  endproperty
  a_s2_zero: assert property (p_s2_zero) else $error("status_two upper bits set");
  property p_dh_zero;
    i_rd && i_addr == 8'h76 |=> o_rdata[5:0] == 6'h00;
  endproperty
  a_dh_zero: assert property (p_dh_zero) else $error("data_high low bits set");
  property p_irq_src;
    o_irq |-> $past(ctl_ff[7:4]) != 4'h0;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("request with no enable");
  property p_irq_off;
    i_wr && i_addr == 8'h73 && i_wdata[7:4] == 4'h0 |=> ##1 !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request after disable");
  property p_irq_sleep;
    o_irq && $past(ctl_ff[1]) |-> $past(ctl_ff[7:6]) != 2'b00;
  endproperty
  a_irq_sleep: assert property (p_irq_sleep) else $error("receiver request asleep");
  property p_oe_rise;
    $rose(o_tx_oe) |-> ctl_ff[3] || $past(ctl_ff[3]);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("pin taken while off");
  property p_low_owned;
    !o_tx_pin |-> o_tx_oe;
  endproperty
  a_low_owned: assert property (p_low_owned) else $error("pin low while released");
  c_irq: cover property (o_irq);
  c_oe: cover property ($rose(o_tx_oe));
  c_s2: cover property (i_rd && i_addr == 8'h75);
endmodule // serial_unit_checker
bind async_serial_unit serial_unit_checker u_serial_unit_checker (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_pin(i_rx_pin),
  .o_tx_pin(o_tx_pin), .o_tx_oe(o_tx_oe), .o_irq(o_irq));
`default_nettype wire

// ==== serial_node.sv ====
// Remote serial node: sends frames to the receiver and captures transmitted frames.
`timescale 1ns/10ps
`default_nettype none
module serial_node #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic i_mclk,
  input  wire logic i_tx_pin,
  output logic      o_rx_line
);
  logic [8:0] got;
  logic       stop_seen;
  int         nbits = 8;
  int         n_got = 0;
  initial o_rx_line = 1'b1;
  // Start bit, data least significant bit first, then the given stop level.
  task automatic send(input logic [8:0] d, input logic stop);
    for (int i = -1; i <= nbits; i++)
    begin
      o_rx_line <= (i < 0) ? 1'b0 : (i == nbits) ? stop : d[i];
      repeat (BIT_CLKS) @(posedge i_mclk);
    end
    o_rx_line <= 1'b1;
  endtask
  initial
  begin
    forever
    begin
      @(negedge i_tx_pin);
      got = 9'h000;
      repeat (BIT_CLKS / 2) @(posedge i_mclk);
      for (int i = 0; i < nbits; i++)
      begin
        repeat (BIT_CLKS) @(posedge i_mclk);
        got[i] = i_tx_pin;
      end
      repeat (BIT_CLKS) @(posedge i_mclk);
      stop_seen = i_tx_pin;
      n_got++;
    end
  end
endmodule // serial_node
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench of the serial unit.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import serial_unit_pkg::*;
  logic       i_mclk = 1'b0;
  logic       i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  byte_t      i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] o_rdata, d;
  logic       rx_line, o_tx_pin, o_tx_oe, o_irq;
  int         n_fail = 0, checks = 0, cycles = 0, n0;
  async_serial_unit #(.TICK_DIV(1)) u_async_serial_unit (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_pin(rx_line),
    .o_tx_pin(o_tx_pin), .o_tx_oe(o_tx_oe), .o_irq(o_irq));
  serial_node #(.BIT_CLKS(16)) u_serial_node (
    .i_mclk(i_mclk), .i_tx_pin(o_tx_pin), .o_rx_line(rx_line));
  initial forever #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, m, e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    chk(nm, {1'b0, e}, {1'b0, d & m});
  endtask
  task automatic irqc(input logic e);
    repeat (8) @(posedge i_mclk);
    #1 chk("irq", {8'h00, e}, {8'h00, o_irq});
  endtask
  task automatic frame();
    n0 = u_serial_node.n_got;
    while (u_serial_node.n_got == n0) @(posedge i_mclk);
  endtask
  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rdc("status_one", 8'h74, 8'hff, 8'hc0);
    rdc("status_two", 8'h75, 8'hff, 8'h00);
    rdc("unmapped", 8'h10, 8'hff, 8'h00);
    wr(8'h73, 8'h08);
    rdc("control_two", 8'h73, 8'hff, 8'h08);
    rdc("status_one", 8'h74, 8'hc0, 8'hc0);
    wr(8'h77, 8'h5a);
    repeat (8) @(posedge i_mclk);
    rdc("status_one", 8'h74, 8'hc0, 8'h80);
    frame();
    chk("tx_char", 9'h05a, u_serial_node.got);
    chk("tx_stop", 9'h001, {8'h00, u_serial_node.stop_seen});
    repeat (20) @(posedge i_mclk);
    rdc("status_one", 8'h74, 8'hc0, 8'hc0);
    wr(8'h73, 8'h48);
    irqc(1'b1);
    wr(8'h73, 8'h08);
    irqc(1'b0);
    wr(8'h73, 8'h88);
    irqc(1'b1);
    wr(8'h72, 8'h10);
    u_serial_node.nbits = 9;
    wr(8'h76, 8'h40);
    wr(8'h77, 8'ha5);
    frame();
    chk("tx_ninth", 9'h1a5, u_serial_node.got);
    rdc("data_high", 8'h76, 8'hff, 8'h40);
    repeat (20) @(posedge i_mclk);
    wr(8'h72, 8'h00);
    u_serial_node.nbits = 8;
    wr(8'h73, 8'h2c);
    u_serial_node.send(9'h03c, 1'b1);
    irqc(1'b1);
    rdc("rx_flags", 8'h74, 8'h28, 8'h20);
    rdc("data_low", 8'h77, 8'hff, 8'h3c);
    rdc("rx_flags", 8'h74, 8'h28, 8'h00);
    irqc(1'b0);
    u_serial_node.send(9'h011, 1'b1);
    u_serial_node.send(9'h022, 1'b1);
    irqc(1'b1);
    rdc("rx_flags", 8'h74, 8'h28, 8'h28);
    rdc("data_low", 8'h77, 8'hff, 8'h11);
    rdc("rx_flags", 8'h74, 8'h28, 8'h00);
    wr(8'h73, 8'h0c);
    u_serial_node.send(9'h033, 1'b0);
    irqc(1'b0);
    rdc("rx_flags", 8'h74, 8'h22, 8'h22);
    rdc("data_low", 8'h77, 8'hff, 8'h33);
    rdc("rx_flags", 8'h74, 8'h02, 8'h00);
    wr(8'h72, 8'h02);
    u_serial_node.send(9'h001, 1'b1);
    repeat (8) @(posedge i_mclk);
    rdc("parity", 8'h74, 8'h21, 8'h21);
    rdc("data_low", 8'h77, 8'hff, 8'h01);
    rdc("parity", 8'h74, 8'h01, 8'h00);
    wr(8'h72, 8'h00);
    wr(8'h73, 8'h1c);
    u_serial_node.send(9'h044, 1'b1);
    repeat (100) @(posedge i_mclk);
    rdc("idle", 8'h74, 8'h10, 8'h00);
    repeat (100) @(posedge i_mclk);
    rdc("idle", 8'h74, 8'h10, 8'h10);
    irqc(1'b1);
    rdc("data_low", 8'h77, 8'hff, 8'h44);
    repeat (200) @(posedge i_mclk);
    rdc("idle", 8'h74, 8'h10, 8'h00);
    wr(8'h73, 8'h3e);
    u_serial_node.send(9'h055, 1'b1);
    repeat (200) @(posedge i_mclk);
    rdc("asleep", 8'h74, 8'h30, 8'h00);
    irqc(1'b0);
    wr(8'h73, 8'h0c);
    fork
      u_serial_node.send(9'h066, 1'b1);
      begin
        repeat (60) @(posedge i_mclk);
        rdc("busy", 8'h75, 8'hff, 8'h01);
      end
    join
    repeat (20) @(posedge i_mclk);
    rdc("busy", 8'h75, 8'hff, 8'h00);
    wr(8'h73, 8'h09);
    frame();
    chk("brk_char", 9'h000, u_serial_node.got);
    chk("brk_stop", 9'h000, {8'h00, u_serial_node.stop_seen});
    repeat (100) @(posedge i_mclk);
    chk("brk_line", 9'h000, {8'h00, o_tx_pin});
    wr(8'h73, 8'h08);
    repeat (400) @(posedge i_mclk);
    chk("tx_line", 9'h001, {8'h00, o_tx_pin});
    wr(8'h77, 8'h71);
    wr(8'h77, 8'h72);
    wr(8'h73, 8'h00);
    frame();
    chk("last_char", 9'h071, u_serial_node.got);
    repeat (400) @(posedge i_mclk);
    chk("frames", 9'(n0 + 1), 9'(u_serial_node.n_got));
    chk("tx_oe", 9'h000, {8'h00, o_tx_oe});
    rdc("status_one", 8'h74, 8'hc0, 8'hc0);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
